// >>> core/trip_vote_pkg.sv
// Package of constants, enumerations and carrier types for the division trip voting logic
`default_nettype none

package trip_vote_pkg;

  // ************************************************************
  // Division and train structure
  // ************************************************************
  localparam int NDIV       = 4;   // Instrumentation divisions
  localparam int VOTE_MIN   = 2;   // Coincident trips needed, with or without a bypass
  localparam int STD_TRAINS = 2;   // Redundant vote trains per division
  localparam int DPV_TRAINS = 3;   // Trains for the depressurization valve path
  localparam int NUM_VARS   = 8;   // Safety functions handled by this division
  localparam int VAL_W      = 16;  // Width of a processed sensor value

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 25;   // Core clock rate
  localparam int BYP_TIMEOUT_US  = 100;  // Longest silence of a bypass switch link
  localparam int BYP_TIMEOUT_CYC = (BYP_TIMEOUT_US * CLK_MHZ > 0) ? BYP_TIMEOUT_US * CLK_MHZ : 1;

  // ************************************************************
  // Bypass interlock states and status carrier
  // ************************************************************
  typedef enum logic [1:0] {
    BYP_NONE = 2'h1,
    BYP_HELD = 2'h2
  } byp_state_e;

  typedef struct packed {
    logic            active;     // A sensor division is bypassed, voting is two-of-three
    logic            reject;     // A second bypass request is being refused
    logic [NDIV-1:0] link_lost;  // Bypass switch links timed out
    logic [NDIV-1:0] division;   // One-hot bypassed division
  } byp_status_s;

endpackage : trip_vote_pkg

`default_nettype wire

// >>> core/division_trip_vote.sv
// Per-division setpoint comparison, redundant two-of-four voting, bypass interlock and alarms
`timescale 1ns/1ps
`default_nettype none

module division_trip_vote #(
  parameter int NV              = trip_vote_pkg::NUM_VARS,
  parameter int VW              = trip_vote_pkg::VAL_W,
  parameter int OWN_DIV         = 0,
  parameter int DPV_FUNC        = 0,
  parameter int BYP_TIMEOUT_CYC = trip_vote_pkg::BYP_TIMEOUT_CYC
) (
  input  wire logic                                         CLK,
  input  wire logic                                         RST,
  input  wire logic [NV-1:0][VW-1:0]                        SENSOR_VAL,
  input  wire logic [NV-1:0][VW-1:0]                        SETPOINT,
  input  wire logic [NV-1:0]                                TRIP_BELOW,
  input  wire logic [trip_vote_pkg::NDIV-1:0][NV-1:0]       REMOTE_TRIP,
  input  wire logic [trip_vote_pkg::NDIV-1:0]               BYP_SW,
  input  wire logic [trip_vote_pkg::NDIV-1:0]               BYP_UPD,
  input  wire logic [NV-1:0]                                MANUAL_INIT,
  input  wire logic [NV-1:0]                                SEQ_DONE,
  input  wire logic [trip_vote_pkg::STD_TRAINS-1:0]         STD_FAULT,
  input  wire logic [trip_vote_pkg::DPV_TRAINS-1:0]         DPV_FAULT,
  input  wire logic                                         ALARM_ACK,
  output logic      [trip_vote_pkg::STD_TRAINS-1:0][NV-1:0] ESF_TRAIN_TRIP,
  output logic      [trip_vote_pkg::DPV_TRAINS-1:0]         DPV_TRAIN_TRIP,
  output logic      [trip_vote_pkg::STD_TRAINS-1:0]         TRAIN_ALARM,
  output logic      [trip_vote_pkg::DPV_TRAINS-1:0]         DPV_ALARM,
  output trip_vote_pkg::byp_status_s                        BYP_STATUS
);

  // ************************************************************
  // Local types and helpers
  // ************************************************************
  localparam int ND   = trip_vote_pkg::NDIV;
  localparam int NS   = trip_vote_pkg::STD_TRAINS;
  localparam int NP   = trip_vote_pkg::DPV_TRAINS;
  localparam int TO_W = $clog2(BYP_TIMEOUT_CYC + 1);
  localparam logic [TO_W-1:0] TO_LAST = TO_W'(BYP_TIMEOUT_CYC - 1);

  typedef struct packed {
    logic [ND-1:0][NV-1:0]   div_q;     // Registered flags of all four divisions
    logic [ND-1:0]           sw_q;      // Last switch position received per division
    logic [ND-1:0][TO_W-1:0] tmo;       // Silence counters of the switch links
    logic [ND-1:0]           lost;      // Switch links declared lost
    trip_vote_pkg::byp_state_e byp_st;  // Interlock state
    logic [ND-1:0]           byp;       // Accepted bypass, one-hot or zero
    logic                    reject;    // Second request refused
    logic [NS-1:0][NV-1:0]   std_lat;   // Latched trips of the ordinary trains
    logic [NP-1:0]           dpv_lat;   // Latched trips of the valve path trains
    logic [NV-1:0]           ref_lat;   // Checker copy of the latched trips
    logic [NS-1:0]           std_alarm; // Sticky train failure alarms
    logic [NP-1:0]           dpv_alarm; // Sticky valve path train alarms
  } state_s;

  localparam state_s ST_RST = '{byp_st: trip_vote_pkg::BYP_NONE, default: '0};

  // Number of set bits among the four divisions
  function automatic logic [2:0] count4(input logic [ND-1:0] bits);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < ND; i++) begin
      n = n + {2'h0, bits[i]};
    end
    return n;
  endfunction : count4

  // Coincidence vote of one function with bypassed divisions masked out
  function automatic logic vote_fn(input logic [ND-1:0] flags, input logic [ND-1:0] mask);
    return count4(flags & ~mask) >= 3'(trip_vote_pkg::VOTE_MIN);
  endfunction : vote_fn

  state_s          st;
  state_s          next_st;
  logic [NV-1:0]   own_flag;
  logic [NV-1:0]   vote_vec;
  logic [ND-1:0]   req;

  // ************************************************************
  // Setpoint trip units and vote decisions
  // ************************************************************

  // Compare each processed value with its setpoint, high or low trip
  always_comb begin
    for (int v = 0; v < NV; v++) begin
      own_flag[v] = TRIP_BELOW[v] ? (SENSOR_VAL[v] <= SETPOINT[v])
                                  : (SENSOR_VAL[v] >= SETPOINT[v]);
    end
  end

  // Coincidence vote of every function over the registered division flags
  always_comb begin
    for (int v = 0; v < NV; v++) begin
      logic [ND-1:0] f;
      f = '0;
      for (int d = 0; d < ND; d++) begin
        f[d] = st.div_q[d][v];
      end
      vote_vec[v] = vote_fn(f, st.byp);
    end
  end

  // Effective bypass requests, a silent switch counts as no bypass
  assign req = st.sw_q & ~st.lost;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;

    // Own flags and remote flags registered together each cycle
    for (int d = 0; d < ND; d++) begin
      next_st.div_q[d] = (d == OWN_DIV) ? own_flag : REMOTE_TRIP[d];
    end

    // Switch link supervision: update refreshes, silence times out
    for (int d = 0; d < ND; d++) begin
      if (BYP_UPD[d]) begin
        next_st.sw_q[d] = BYP_SW[d];
        next_st.tmo[d]  = '0;
        next_st.lost[d] = 1'b0;
      end else if (st.tmo[d] >= TO_LAST) begin
        next_st.lost[d] = 1'b1;
      end else begin
        next_st.tmo[d]  = st.tmo[d] + TO_W'(1);
      end
    end

    // Bypass interlock: one division at a time, others refused
    case (st.byp_st)
      trip_vote_pkg::BYP_NONE: begin
        next_st.reject = count4(req) > 3'h1;
        if (count4(req) == 3'h1) begin
          next_st.byp_st = trip_vote_pkg::BYP_HELD;
          next_st.byp    = req;
        end
      end
      trip_vote_pkg::BYP_HELD: begin
        next_st.reject = (req & ~st.byp) != '0;
        if ((req & st.byp) == '0) begin
          next_st.byp_st = trip_vote_pkg::BYP_NONE;
          next_st.byp    = '0;
        end
      end
      default: begin
        next_st.byp_st = trip_vote_pkg::BYP_NONE;
        next_st.byp    = '0;
        next_st.reject = 1'b0;
      end
    endcase

    // Ordinary trains: latch vote or manual trip until the sequence completes
    for (int t = 0; t < NS; t++) begin
      if (!STD_FAULT[t]) begin
        next_st.std_lat[t] = vote_vec | MANUAL_INIT | (st.std_lat[t] & ~SEQ_DONE);
      end
    end

    // Valve path trains follow the selected function independently
    for (int t = 0; t < NP; t++) begin
      if (!DPV_FAULT[t]) begin
        next_st.dpv_lat[t] = vote_vec[DPV_FUNC] | MANUAL_INIT[DPV_FUNC]
                             | (st.dpv_lat[t] & ~SEQ_DONE[DPV_FUNC]);
      end
    end

    // Checker copy runs every cycle, never halted by a train fault
    next_st.ref_lat = vote_vec | MANUAL_INIT | (st.ref_lat & ~SEQ_DONE);

    // Any train disagreeing with the checker raises a sticky alarm, set beats acknowledge
    for (int t = 0; t < NS; t++) begin
      next_st.std_alarm[t] = (st.std_lat[t] != st.ref_lat) | (st.std_alarm[t] & ~ALARM_ACK);
    end
    for (int t = 0; t < NP; t++) begin
      next_st.dpv_alarm[t] = (st.dpv_lat[t] != st.ref_lat[DPV_FUNC])
                             | (st.dpv_alarm[t] & ~ALARM_ACK);
    end
  end

  // State register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************

  // Each train drives its own series driver; no trip-output bypass on this path
  assign ESF_TRAIN_TRIP = st.std_lat;
  assign DPV_TRAIN_TRIP = st.dpv_lat;
  assign TRAIN_ALARM    = st.std_alarm;
  assign DPV_ALARM      = st.dpv_alarm;

  // Bypass status toward the operator station
  assign BYP_STATUS.active    = st.byp != '0;
  assign BYP_STATUS.reject    = st.reject;
  assign BYP_STATUS.link_lost = st.lost;
  assign BYP_STATUS.division  = st.byp;

  // ************************************************************
  // Assertions
  // ************************************************************

  // Interlock never holds more than one division in bypass
  a_bypass_single: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(st.byp))
    else $error("more than one sensor division bypassed");

  // A single clean request from the idle state is taken on the next edge
  a_bypass_accept: assert property (@(posedge CLK) disable iff (RST)
    (st.byp_st == trip_vote_pkg::BYP_NONE && count4(req) == 3'h1) |=> (st.byp == $past(req)))
    else $error("single bypass request not accepted");

  // Two requests from idle are refused and nothing is taken
  a_idle_reject: assert property (@(posedge CLK) disable iff (RST)
    (st.byp_st == trip_vote_pkg::BYP_NONE && count4(req) > 3'h1) |=> (st.reject && st.byp == '0))
    else $error("second bypass from idle not refused");

  // A further request while one division is held is refused
  a_bypass_reject: assert property (@(posedge CLK) disable iff (RST)
    (st.byp_st == trip_vote_pkg::BYP_HELD && (req & ~st.byp) != '0) |=> st.reject)
    else $error("second bypass while held not refused");

  // Dropping the held request restores two-of-four voting on the next edge
  a_bypass_release: assert property (@(posedge CLK) disable iff (RST)
    (st.byp_st == trip_vote_pkg::BYP_HELD && (req & st.byp) == '0) |=> (st.byp == '0))
    else $error("bypass kept after request removed");

  // A lost switch link removes its bypass one cycle later
  a_bypass_lost: assert property (@(posedge CLK) disable iff (RST)
    ((st.lost & st.byp) != '0) |=> ((st.byp & $past(st.lost)) == '0))
    else $error("bypass kept after switch link loss");

  // Links whose silence counter has run out with no update on this edge
  logic [ND-1:0] tmo_hit;
  always_comb begin
    for (int d = 0; d < ND; d++) begin
      tmo_hit[d] = (st.tmo[d] == TO_LAST) && !BYP_UPD[d];
    end
  end

  // Any silent link is declared lost after the timeout count
  a_link_timeout: assert property (@(posedge CLK) disable iff (RST)
    (tmo_hit != '0) |=> ((st.lost & $past(tmo_hit)) == $past(tmo_hit)))
    else $error("switch link loss not declared");

  // An update on a link clears its loss on the next edge
  a_link_refresh: assert property (@(posedge CLK) disable iff (RST)
    (BYP_UPD != '0) |=> ((st.lost & $past(BYP_UPD)) == '0))
    else $error("updated switch link still lost");

  // Registered flags of the division after OWN_DIV equal its remote inputs of the previous cycle
  a_remote_reg: assert property (@(posedge CLK) disable iff (RST)
    ##1 (st.div_q[(OWN_DIV + 1) % ND] == $past(REMOTE_TRIP[(OWN_DIV + 1) % ND])))
    else $error("remote flags not registered");

  // Own comparator flags are registered with the remote flags
  a_trip_own: assert property (@(posedge CLK) disable iff (RST)
    ##1 (st.div_q[OWN_DIV] == $past(own_flag)))
    else $error("own trip flags not registered");

  // A vote or manual request is latched in the checker on the next edge
  a_vote_latch: assert property (@(posedge CLK) disable iff (RST)
    ((vote_vec | MANUAL_INIT) != '0) |=>
      ((st.ref_lat & $past(vote_vec | MANUAL_INIT)) == $past(vote_vec | MANUAL_INIT)))
    else $error("vote or manual trip not latched");

  // A manual request latches in a healthy ordinary train on the next edge
  a_manual_init: assert property (@(posedge CLK) disable iff (RST)
    (MANUAL_INIT != '0 && !STD_FAULT[0]) |=> ((st.std_lat[0] & $past(MANUAL_INIT)) == $past(MANUAL_INIT)))
    else $error("manual initiation not latched");

  // A manual request on the valve function trips a healthy valve train
  a_dpv_manual: assert property (@(posedge CLK) disable iff (RST)
    (MANUAL_INIT[DPV_FUNC] && !DPV_FAULT[1]) |=> st.dpv_lat[1])
    else $error("manual valve initiation not latched");

  // A latched trip stays until its completion input
  a_latch_hold: assert property (@(posedge CLK) disable iff (RST)
    ##1 (($past(st.std_lat[0]) & ~$past(SEQ_DONE) & ~st.std_lat[0]) == '0 || $past(STD_FAULT[0])))
    else $error("latched trip dropped before completion");

  // Completion with no vote or manual request clears a healthy train
  a_done_clear: assert property (@(posedge CLK) disable iff (RST)
    (SEQ_DONE == '1 && vote_vec == '0 && MANUAL_INIT == '0 && !STD_FAULT[0]) |=> (st.std_lat[0] == '0))
    else $error("latched trip kept after completion");

  // A latched valve trip stays until its completion input
  a_dpv_hold: assert property (@(posedge CLK) disable iff (RST)
    (st.dpv_lat[1] && !SEQ_DONE[DPV_FUNC]) |=> st.dpv_lat[1])
    else $error("latched valve trip dropped before completion");

  // A faulted train holds its outputs as they were
  a_fail_hold: assert property (@(posedge CLK) disable iff (RST)
    DPV_FAULT[0] |=> (st.dpv_lat[0] == $past(st.dpv_lat[0])))
    else $error("faulted train output changed");

  // A faulted ordinary train holds its outputs as they were
  a_std_fail_hold: assert property (@(posedge CLK) disable iff (RST)
    STD_FAULT[1] |=> (st.std_lat[1] == $past(st.std_lat[1])))
    else $error("faulted ordinary train output changed");

  // A train disagreeing with the checker is alarmed on the next edge
  a_train_alarm: assert property (@(posedge CLK) disable iff (RST)
    (st.std_lat[1] != st.ref_lat) |=> TRAIN_ALARM[1])
    else $error("train disagreement not alarmed");

  // A valve train disagreeing with the checker is alarmed on the next edge
  a_dpv_alarm: assert property (@(posedge CLK) disable iff (RST)
    (st.dpv_lat[0] != st.ref_lat[DPV_FUNC]) |=> DPV_ALARM[0])
    else $error("valve train disagreement not alarmed");

  // Acknowledge clears the ordinary train alarms once both ordinary trains agree with the checker
  a_alarm_clear: assert property (@(posedge CLK) disable iff (RST)
    (ALARM_ACK && st.std_lat[0] == st.ref_lat && st.std_lat[1] == st.ref_lat) |=> (TRAIN_ALARM == '0))
    else $error("train alarm not cleared by acknowledge");

  // Status stays up for the whole time a bypass is held
  a_bypass_shown: assert property (@(posedge CLK) disable iff (RST)
    BYP_STATUS.active == (st.byp_st == trip_vote_pkg::BYP_HELD))
    else $error("bypass active status missing");

  // Interlock state register always holds one legal one-hot code
  a_state_legal: assert property (@(posedge CLK) disable iff (RST)
    $onehot(st.byp_st))
    else $error("interlock state code illegal");

  // Main scenarios
  c_bypass_taken: cover property (@(posedge CLK) disable iff (RST)
    st.byp_st == trip_vote_pkg::BYP_NONE ##1 st.byp_st == trip_vote_pkg::BYP_HELD);
  c_second_reject: cover property (@(posedge CLK) disable iff (RST)
    st.reject && st.byp_st == trip_vote_pkg::BYP_HELD);
  c_dpv_trip: cover property (@(posedge CLK) disable iff (RST)
    st.dpv_lat == '1);
  c_train_fail: cover property (@(posedge CLK) disable iff (RST)
    st.std_alarm != '0);
  c_link_lost: cover property (@(posedge CLK) disable iff (RST)
    st.lost != '0);

endmodule : division_trip_vote

`default_nettype wire

// >>> dv/remote_divisions.sv
// Behavioural model of the remote divisions, bypass switch links and output unit
`timescale 1ns/1ps
`default_nettype none

module remote_divisions (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic [3:0][trip_vote_pkg::NUM_VARS-1:0] flags,
  input  wire logic [3:0]                              byp_req,
  input  wire logic [3:0]                              link_on,
  input  wire logic [1:0][trip_vote_pkg::NUM_VARS-1:0] train_trip,
  input  wire logic                                    keylock,
  output logic      [3:0][trip_vote_pkg::NUM_VARS-1:0] remote_trip,
  output logic      [3:0]                              byp_sw,
  output logic      [3:0]                              byp_upd,
  output logic      [trip_vote_pkg::NUM_VARS-1:0]      actuate
);
  logic [7:0] tick;

  // Network delivers remote flags one cycle late; live switch links update every fourth cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick        <= 8'h00;
      remote_trip <= '0;
      byp_sw      <= 4'h0;
      byp_upd     <= 4'h0;
    end else begin
      tick        <= tick + 8'h01;
      remote_trip <= flags;
      byp_upd     <= link_on & {4{tick[1:0] == 2'h0}};
      byp_sw      <= (byp_req & link_on) | (~byp_sw & ~link_on); // Dead link shows a toggling line
    end
  end

  // Output unit fires only when both trains agree and the keylock is off
  assign actuate = train_trip[0] & train_trip[1] & {trip_vote_pkg::NUM_VARS{~keylock}};
endmodule : remote_divisions
`default_nettype wire

// >>> dv/division_trip_vote_bench.sv
// Self-checking bench for the division trip voting logic
`timescale 1ns/1ps
`default_nettype none

module division_trip_vote_bench;
  localparam int NV = trip_vote_pkg::NUM_VARS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ack = 1'b0;
  logic keylock = 1'b0;
  logic [NV-1:0][15:0] sval = '0;
  logic [NV-1:0][15:0] spt = '1;
  logic [NV-1:0] below = '0;
  logic [NV-1:0] man = '0;
  logic [NV-1:0] done = '0;
  logic [NV-1:0] act;
  logic [3:0][NV-1:0] flags = '0;
  logic [3:0][NV-1:0] rtrip;
  logic [3:0] breq = '0;
  logic [3:0] lon = '1;
  logic [3:0] bsw;
  logic [3:0] bupd;
  logic [1:0] sfault = '0;
  logic [2:0] dfault = '0;
  logic [1:0][NV-1:0] esf;
  logic [2:0] depressurization_valve_path;
  logic [1:0] talm;
  logic [2:0] dalm;
  trip_vote_pkg::byp_status_s bst;
  int err_count = 0;
  int samples_checked = 0;

  division_trip_vote #(.BYP_TIMEOUT_CYC(8)) u_dut (
    .CLK(clk), .RST(rst), .SENSOR_VAL(sval), .SETPOINT(spt), .TRIP_BELOW(below),
    .REMOTE_TRIP(rtrip), .BYP_SW(bsw), .BYP_UPD(bupd), .MANUAL_INIT(man), .SEQ_DONE(done),
    .STD_FAULT(sfault), .DPV_FAULT(dfault), .ALARM_ACK(ack), .ESF_TRAIN_TRIP(esf),
    .DPV_TRAIN_TRIP(depressurization_valve_path), .TRAIN_ALARM(talm), .DPV_ALARM(dalm), .BYP_STATUS(bst));

  remote_divisions u_far (
    .clk(clk), .rst(rst), .flags(flags), .byp_req(breq), .link_on(lon), .train_trip(esf),
    .keylock(keylock), .remote_trip(rtrip), .byp_sw(bsw), .byp_upd(bupd), .actuate(act));

  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end

  // ************************************************************
  // Expectation and reporting helpers
  // ************************************************************
  // Vote over own comparators and remote flags with the bypassed division masked
  function automatic logic [NV-1:0] vote(input logic [3:0] byp);
    int n;
    for (int v = 0; v < NV; v++) begin
      n = 0;
      for (int d = 0; d < 4; d++) begin
        if (d == 0) begin
          n += int'((below[v] ? sval[v] <= spt[v] : sval[v] >= spt[v]) & ~byp[0]);
        end else begin
          n += int'(flags[d][v] & ~byp[d]);
        end
      end
      vote[v] = (n >= 2);
    end
  endfunction : vote

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Bounded wait for one status bit
  task automatic wait_st(input int idx, input logic val);
    int n;
    n = 0;
    while (bst[idx] !== val && n < 40) begin
      step(1);
      n++;
    end
    if (bst[idx] !== val) begin
      err_count++;
      results();
    end
  endtask : wait_st

  // One random vote, then release of the cause, then completion
  task automatic round(input logic [3:0] byp, input bit eq);
    logic [NV-1:0][15:0] r;
    logic [NV-1:0] exp;
    r = {$urandom, $urandom, $urandom, $urandom};
    @(posedge clk);
    sval <= r;
    spt <= eq ? r : {$urandom, $urandom, $urandom, $urandom};
    below <= NV'($urandom);
    flags <= $urandom & $urandom;
    keylock <= 1'($urandom);
    step(1);
    exp = vote(byp);
    step(4);
    check(esf, {exp, exp});
    check(depressurization_valve_path, {3{exp[0]}});
    check(act, exp & {NV{~keylock}});
    check(talm, 2'h0);
    @(posedge clk);
    sval <= '0;
    spt <= '1;
    below <= '0;
    flags <= '0;
    step(5);
    check(esf[0], exp);
    @(posedge clk);
    done <= '1;
    @(posedge clk);
    done <= '0;
    step(3);
    check(esf, 0);
  endtask : round

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'h30F4));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    step(1);
    check(esf, 0);
    check(bst, 0);
    round(4'h0, 1'b1);
    repeat (30) round(4'h0, 1'b0);
    // Manual initiation with one frozen train in each path
    @(posedge clk);
    man <= 8'h81;
    sfault <= 2'h2;
    dfault <= 3'h1;
    @(posedge clk);
    man <= '0;
    step(4);
    check(esf, {8'h00, 8'h81});
    check(depressurization_valve_path, 3'h6);
    check(talm, 2'h2);
    check(dalm, 3'h1);
    @(posedge clk);
    sfault <= '0;
    dfault <= '0;
    done <= '1;
    @(posedge clk);
    done <= '0;
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    step(2);
    check({talm, dalm, depressurization_valve_path}, 0);
    // Sensor-division bypass, second request and lost link
    @(posedge clk);
    breq <= 4'h4;
    wait_st(9, 1'b1);
    check(bst.division, 4'h4);
    repeat (20) round(4'h4, 1'b0);
    check(bst.active, 1'b1);
    @(posedge clk);
    breq <= 4'hC;
    wait_st(8, 1'b1);
    check(bst.division, 4'h4);
    @(posedge clk);
    breq <= 4'h4;
    wait_st(8, 1'b0);
    @(posedge clk);
    lon <= 4'hB;
    wait_st(6, 1'b1);
    step(2);
    check({bst.active, bst.division}, 0);
    repeat (10) round(4'h0, 1'b0);
    // Two requests at once from idle are refused and nothing is taken
    @(posedge clk);
    breq <= 4'h3;
    wait_st(8, 1'b1);
    check({bst.active, bst.division}, 0);
    @(posedge clk);
    breq <= 4'h0;
    wait_st(8, 1'b0);
    results();
  end
endmodule : division_trip_vote_bench
`default_nettype wire
